// >>> logic/msag_params.svh
/*
  Constants for the memory space address generator: widths, bit positions,
  boundaries and reset values. Definitions only; included by bare name.
*/
`ifndef MSAG_PARAMS_SVH
`define MSAG_PARAMS_SVH

// ---------------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------------
`define MSAG_PC_W        23
`define MSAG_PADDR_W     24
`define MSAG_EA_W        16
`define MSAG_RPAGE_W     10
`define MSAG_WPAGE_W     9
`define MSAG_TPAGE_W     8

// ---------------------------------------------------------------------------
// Bit positions
// ---------------------------------------------------------------------------
`define MSAG_EA_HI_BIT   15
`define MSAG_RPAGE_PSV   9
`define MSAG_TPAGE_CFG   7

// ---------------------------------------------------------------------------
// Fixed values
// ---------------------------------------------------------------------------
`define MSAG_USER_TOP    24'h7FFFFF
`define MSAG_XY_BOUND    16'h4000
`define MSAG_RPAGE_RST   10'h000
`define MSAG_WPAGE_RST   9'h000
`define MSAG_PADDR_ZERO  24'h000000
`define MSAG_EA_ZERO     16'h0000

`endif

// >>> logic/msag_pkg.sv
/*
  Types of the memory space address generator.
  Assumes msag_params.svh is on the include path.
*/
`include "msag_params.svh"

package msag_pkg;

  // -------------------------------------------------------------------------
  // Pointer update settings for one address generator.
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [`MSAG_EA_W-1:0] step;      // Signed pointer modifier.
    logic                  pre;       // Use the modified pointer as address.
    logic                  mod_en;    // Circular addressing enabled.
    logic [`MSAG_EA_W-1:0] mod_start; // First address of the circular buffer.
    logic [`MSAG_EA_W-1:0] mod_end;   // Last address of the circular buffer.
    logic                  brev_en;   // Bit-reversed update requested.
  } msag_agu_cfg_t;

  // -------------------------------------------------------------------------
  // Kind of program space access.
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MSAG_PS_FETCH,
    MSAG_PS_TBL_RD,
    MSAG_PS_TBL_WR
  } msag_ps_kind_t;

endpackage : msag_pkg

// >>> logic/msag_agu.sv
/*
  One address generation unit: combinational pointer update with linear,
  circular and bit-reversed modes. Assumes the caller registers results.
*/
`timescale 1ns/10ps
`include "msag_params.svh"

module msag_agu (
  input  wire logic [`MSAG_EA_W-1:0] ptr_i,
  input  wire msag_pkg::msag_agu_cfg_t cfg_i,
  output logic      [`MSAG_EA_W-1:0] ea_o,
  output logic      [`MSAG_EA_W-1:0] ptr_next_o
);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // Bit reversal, used three times in the reverse-carry update.
  function automatic logic [`MSAG_EA_W-1:0] msag_rev(
    input logic [`MSAG_EA_W-1:0] v
  );
    logic [`MSAG_EA_W-1:0] r;
    r = `MSAG_EA_ZERO;
    for (int i = 0; i < `MSAG_EA_W; i++) begin
      r[i] = v[`MSAG_EA_W-1-i];
    end
    return r;
  endfunction : msag_rev

  logic [`MSAG_EA_W-1:0] lin_sum;  // Plain two's complement update.

  // -------------------------------------------------------------------------
  // Pointer update
  // -------------------------------------------------------------------------
  // Circular wrap compares against the boundary reached in the step's
  // direction; a step that jumps past the boundary is not folded back.
  always_comb begin
    lin_sum = ptr_i + cfg_i.step;
    if (cfg_i.brev_en) begin
      ptr_next_o = msag_rev(msag_rev(ptr_i) + msag_rev(cfg_i.step));
    end else if (cfg_i.mod_en && !cfg_i.step[`MSAG_EA_W-1] &&
                 ptr_i == cfg_i.mod_end) begin
      ptr_next_o = cfg_i.mod_start;
    end else if (cfg_i.mod_en && cfg_i.step[`MSAG_EA_W-1] &&
                 ptr_i == cfg_i.mod_start) begin
      ptr_next_o = cfg_i.mod_end;
    end else begin
      ptr_next_o = lin_sum;
    end
    ea_o = cfg_i.pre ? ptr_next_o : ptr_i;
  end

endmodule : msag_agu

// >>> logic/msag_prog_addr.sv
/*
  Program space address former for fetch and table accesses.
  Assumes inputs are stable in the cycle they are sampled.
*/
`timescale 1ns/10ps
`include "msag_params.svh"

module msag_prog_addr (
  input  wire msag_pkg::msag_ps_kind_t   kind_i,
  input  wire logic [`MSAG_PC_W-1:0]     pc_i,
  input  wire logic [`MSAG_TPAGE_W-1:0]  table_page_i,
  input  wire logic [`MSAG_EA_W-1:0]     tbl_ea_i,
  output logic      [`MSAG_PADDR_W-1:0]  addr_o,
  output logic                           fault_o
);

  // -------------------------------------------------------------------------
  // Address selection
  // -------------------------------------------------------------------------
  // Only a table read may reach the upper half; anything else landing
  // there is refused rather than silently wrapped.
  always_comb begin
    unique case (kind_i)
      msag_pkg::MSAG_PS_FETCH: begin
        addr_o = {1'b0, pc_i[`MSAG_PC_W-1:1], 1'b0};
      end
      default: begin
        addr_o = {table_page_i, tbl_ea_i};
      end
    endcase
    fault_o = (addr_o > `MSAG_USER_TOP) &&
              !(kind_i == msag_pkg::MSAG_PS_TBL_RD &&
                table_page_i[`MSAG_TPAGE_CFG]);
  end

endmodule : msag_prog_addr

// >>> logic/msag_top.sv
/*
  Memory space address generator: program space addresses, X and Y data
  address generators, and extended data space paging.
  Assumes one request of each kind per cycle from the instruction datapath,
  synchronous to clk_sys_i; the memory arrays take registered addresses.
*/
`timescale 1ns/10ps
`include "msag_params.svh"

module msag_top (
  input  wire logic                          clk_sys_i,
  input  wire logic                          resetn_i,
  input  wire logic                          ce_i,
  // Page register writes from the special function register space.
  input  wire logic                          rpage_wr_i,
  input  wire logic [`MSAG_RPAGE_W-1:0]      rpage_wdata_i,
  input  wire logic                          wpage_wr_i,
  input  wire logic [`MSAG_WPAGE_W-1:0]      wpage_wdata_i,
  // Program space request.
  input  wire logic                          ps_req_i,
  input  wire msag_pkg::msag_ps_kind_t       ps_kind_i,
  input  wire logic [`MSAG_PC_W-1:0]         pc_i,
  input  wire logic [`MSAG_TPAGE_W-1:0]      table_page_i,
  input  wire logic [`MSAG_EA_W-1:0]         tbl_ea_i,
  // X read request.
  input  wire logic                          x_rd_req_i,
  input  wire logic [`MSAG_EA_W-1:0]         x_rd_ptr_i,
  input  wire msag_pkg::msag_agu_cfg_t       x_rd_cfg_i,
  // X write request.
  input  wire logic                          x_wr_req_i,
  input  wire logic [`MSAG_EA_W-1:0]         x_wr_ptr_i,
  input  wire msag_pkg::msag_agu_cfg_t       x_wr_cfg_i,
  // Y read request.
  input  wire logic                          y_rd_req_i,
  input  wire logic                          mac_class_i,
  input  wire logic [`MSAG_EA_W-1:0]         y_rd_ptr_i,
  input  wire msag_pkg::msag_agu_cfg_t       y_rd_cfg_i,
  // Page register contents.
  output logic      [`MSAG_RPAGE_W-1:0]      data_read_page_o,
  output logic      [`MSAG_WPAGE_W-1:0]      data_write_page_o,
  // Program space answer.
  output logic                               ps_valid_o,
  output logic      [`MSAG_PADDR_W-1:0]      ps_addr_o,
  output logic                               ps_fault_o,
  // X read answer.
  output logic                               x_rd_valid_o,
  output logic      [`MSAG_PADDR_W-1:0]      x_rd_addr_o,
  output logic                               x_rd_window_o,
  output logic      [`MSAG_EA_W-1:0]         x_rd_ptr_o,
  // X write answer.
  output logic                               x_wr_valid_o,
  output logic      [`MSAG_PADDR_W-1:0]      x_wr_addr_o,
  output logic                               x_wr_in_y_o,
  output logic      [`MSAG_EA_W-1:0]         x_wr_ptr_o,
  // Y read answer.
  output logic                               y_rd_valid_o,
  output logic      [`MSAG_EA_W-1:0]         y_rd_addr_o,
  output logic      [`MSAG_EA_W-1:0]         y_rd_ptr_o
);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // Joins a page onto the low effective address bits when the upper bit of
  // the address is set; otherwise the base space is addressed untouched.
  // Shared by the read and write paths.
  function automatic logic [`MSAG_PADDR_W-1:0] msag_page_join(
    input logic [`MSAG_WPAGE_W-1:0] page,
    input logic [`MSAG_EA_W-1:0]    ea
  );
    logic [`MSAG_PADDR_W-1:0] a;
    a = `MSAG_PADDR_ZERO;
    if (ea[`MSAG_EA_HI_BIT]) begin
      a = {page, ea[`MSAG_EA_HI_BIT-1:0]};
    end else begin
      a = {8'h00, ea};
    end
    return a;
  endfunction : msag_page_join

  // -------------------------------------------------------------------------
  // Page registers
  // -------------------------------------------------------------------------
  logic [`MSAG_RPAGE_W-1:0] rpage_reg;   // Read page, ten bits.
  logic [`MSAG_RPAGE_W-1:0] rpage_next;  // Next read page.
  logic [`MSAG_WPAGE_W-1:0] wpage_reg;   // Write page, nine bits.
  logic [`MSAG_WPAGE_W-1:0] wpage_next;  // Next write page.

  // Software writes land here; the new page applies from the next cycle,
  // so a write and an access in the same cycle use the old page.
  always_comb begin
    rpage_next = rpage_wr_i ? rpage_wdata_i : rpage_reg;
    wpage_next = wpage_wr_i ? wpage_wdata_i : wpage_reg;
  end

  // Registers the page values.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rpage_reg <= `MSAG_RPAGE_RST;
      wpage_reg <= `MSAG_WPAGE_RST;
    end else if (ce_i) begin
      rpage_reg <= rpage_next;
      wpage_reg <= wpage_next;
    end
  end

  // -------------------------------------------------------------------------
  // Program space address
  // -------------------------------------------------------------------------
  logic [`MSAG_PADDR_W-1:0] ps_addr_c;   // Formed program address.
  logic                     ps_fault_c;  // Access outside the allowed range.

  msag_prog_addr u_prog (
    .kind_i       (ps_kind_i),
    .pc_i         (pc_i),
    .table_page_i (table_page_i),
    .tbl_ea_i     (tbl_ea_i),
    .addr_o       (ps_addr_c),
    .fault_o      (ps_fault_c)
  );

  // -------------------------------------------------------------------------
  // Data address generators
  // -------------------------------------------------------------------------
  logic [`MSAG_EA_W-1:0]   x_rd_ea;       // X read effective address.
  logic [`MSAG_EA_W-1:0]   x_rd_pn;       // X read updated pointer.
  logic [`MSAG_EA_W-1:0]   x_wr_ea;       // X write effective address.
  logic [`MSAG_EA_W-1:0]   x_wr_pn;       // X write updated pointer.
  logic [`MSAG_EA_W-1:0]   y_rd_ea;       // Y read effective address.
  logic [`MSAG_EA_W-1:0]   y_rd_pn;       // Y read updated pointer.
  msag_pkg::msag_agu_cfg_t x_rd_cfg_c;    // X read settings, reverse cleared.
  msag_pkg::msag_agu_cfg_t y_rd_cfg_c;    // Y read settings, reverse cleared.

  // Bit reverse is stripped on every read path; only the X write keeps it.
  always_comb begin
    x_rd_cfg_c         = x_rd_cfg_i;
    x_rd_cfg_c.brev_en = 1'b0;
    y_rd_cfg_c         = y_rd_cfg_i;
    y_rd_cfg_c.brev_en = 1'b0;
  end

  // Three units give independent X read, X write and Y read paths so that
  // a multiply-accumulate can fetch X and Y in the same cycle.
  msag_agu u_x_rd (
    .ptr_i      (x_rd_ptr_i),
    .cfg_i      (x_rd_cfg_c),
    .ea_o       (x_rd_ea),
    .ptr_next_o (x_rd_pn)
  );

  msag_agu u_x_wr (
    .ptr_i      (x_wr_ptr_i),
    .cfg_i      (x_wr_cfg_i),
    .ea_o       (x_wr_ea),
    .ptr_next_o (x_wr_pn)
  );

  msag_agu u_y_rd (
    .ptr_i      (y_rd_ptr_i),
    .cfg_i      (y_rd_cfg_c),
    .ea_o       (y_rd_ea),
    .ptr_next_o (y_rd_pn)
  );

  // -------------------------------------------------------------------------
  // Address answers
  // -------------------------------------------------------------------------
  logic                     ps_valid_reg,  ps_valid_next;
  logic [`MSAG_PADDR_W-1:0] ps_addr_reg,   ps_addr_next;
  logic                     ps_fault_reg,  ps_fault_next;
  logic                     xr_valid_reg,  xr_valid_next;
  logic [`MSAG_PADDR_W-1:0] xr_addr_reg,   xr_addr_next;
  logic                     xr_win_reg,    xr_win_next;
  logic [`MSAG_EA_W-1:0]    xr_ptr_reg,    xr_ptr_next;
  logic                     xw_valid_reg,  xw_valid_next;
  logic [`MSAG_PADDR_W-1:0] xw_addr_reg,   xw_addr_next;
  logic                     xw_in_y_reg,   xw_in_y_next;
  logic [`MSAG_EA_W-1:0]    xw_ptr_reg,    xw_ptr_next;
  logic                     yr_valid_reg,  yr_valid_next;
  logic [`MSAG_EA_W-1:0]    yr_addr_reg,   yr_addr_next;
  logic [`MSAG_EA_W-1:0]    yr_ptr_reg,    yr_ptr_next;

  // Computes every answer for the next cycle. Pointers hold when no
  // request is made, so the datapath may read them back at any time.
  always_comb begin
    // Program space: a faulting access is reported but not presented.
    ps_fault_next = ps_req_i && ps_fault_c;
    ps_valid_next = ps_req_i && !ps_fault_c;
    ps_addr_next  = ps_valid_next ? ps_addr_c : `MSAG_PADDR_ZERO;

    // X read: combined space, or program window when the read page asks.
    xr_valid_next = x_rd_req_i;
    xr_win_next   = x_rd_req_i && x_rd_ea[`MSAG_EA_HI_BIT] &&
                    rpage_reg[`MSAG_RPAGE_PSV];
    if (!x_rd_req_i) begin
      xr_addr_next = `MSAG_PADDR_ZERO;
    end else if (xr_win_next) begin
      // Window reads hit the lower program half; only its low word is used.
      xr_addr_next = {1'b0, rpage_reg[`MSAG_TPAGE_W-1:0],
                      x_rd_ea[`MSAG_EA_HI_BIT-1:0]};
    end else begin
      xr_addr_next = msag_page_join(rpage_reg[`MSAG_WPAGE_W-1:0],
                                    x_rd_ea);
    end
    xr_ptr_next = x_rd_req_i ? x_rd_pn : xr_ptr_reg;

    // X write: always the combined X and Y space, never the window.
    xw_valid_next = x_wr_req_i;
    xw_addr_next  = x_wr_req_i ? msag_page_join(wpage_reg, x_wr_ea)
                               : `MSAG_PADDR_ZERO;
    xw_in_y_next  = x_wr_req_i && !x_wr_ea[`MSAG_EA_HI_BIT] &&
                    (x_wr_ea >= `MSAG_XY_BOUND);
    xw_ptr_next   = x_wr_req_i ? x_wr_pn : xw_ptr_reg;

    // Y read: second operand path, served only for the MAC class.
    yr_valid_next = y_rd_req_i && mac_class_i;
    yr_addr_next  = yr_valid_next ? y_rd_ea : `MSAG_EA_ZERO;
    yr_ptr_next   = yr_valid_next ? y_rd_pn : yr_ptr_reg;
  end

  // Registers the answers; clock enable low freezes them all.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ps_valid_reg <= 1'b0;
      ps_addr_reg  <= `MSAG_PADDR_ZERO;
      ps_fault_reg <= 1'b0;
      xr_valid_reg <= 1'b0;
      xr_addr_reg  <= `MSAG_PADDR_ZERO;
      xr_win_reg   <= 1'b0;
      xr_ptr_reg   <= `MSAG_EA_ZERO;
      xw_valid_reg <= 1'b0;
      xw_addr_reg  <= `MSAG_PADDR_ZERO;
      xw_in_y_reg  <= 1'b0;
      xw_ptr_reg   <= `MSAG_EA_ZERO;
      yr_valid_reg <= 1'b0;
      yr_addr_reg  <= `MSAG_EA_ZERO;
      yr_ptr_reg   <= `MSAG_EA_ZERO;
    end else if (ce_i) begin
      ps_valid_reg <= ps_valid_next;
      ps_addr_reg  <= ps_addr_next;
      ps_fault_reg <= ps_fault_next;
      xr_valid_reg <= xr_valid_next;
      xr_addr_reg  <= xr_addr_next;
      xr_win_reg   <= xr_win_next;
      xr_ptr_reg   <= xr_ptr_next;
      xw_valid_reg <= xw_valid_next;
      xw_addr_reg  <= xw_addr_next;
      xw_in_y_reg  <= xw_in_y_next;
      xw_ptr_reg   <= xw_ptr_next;
      yr_valid_reg <= yr_valid_next;
      yr_addr_reg  <= yr_addr_next;
      yr_ptr_reg   <= yr_ptr_next;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // -------------------------------------------------------------------------
  assign data_read_page_o  = rpage_reg;
  assign data_write_page_o = wpage_reg;
  assign ps_valid_o        = ps_valid_reg;
  assign ps_addr_o         = ps_addr_reg;
  assign ps_fault_o        = ps_fault_reg;
  assign x_rd_valid_o      = xr_valid_reg;
  assign x_rd_addr_o       = xr_addr_reg;
  assign x_rd_window_o     = xr_win_reg;
  assign x_rd_ptr_o        = xr_ptr_reg;
  assign x_wr_valid_o      = xw_valid_reg;
  assign x_wr_addr_o       = xw_addr_reg;
  assign x_wr_in_y_o       = xw_in_y_reg;
  assign x_wr_ptr_o        = xw_ptr_reg;
  assign y_rd_valid_o      = yr_valid_reg;
  assign y_rd_addr_o       = yr_addr_reg;
  assign y_rd_ptr_o        = yr_ptr_reg;

endmodule : msag_top

// >>> dv/msag_top_sva.sv
/* Checker for the memory space address generator, seeing only top ports.
   Assumes one clock domain with a synchronous active-low reset; bound by name. */
`timescale 1ns/10ps
module msag_top_sva (
  input wire logic                    clk_sys_i,
  input wire logic                    resetn_i,
  input wire logic                    ce_i,
  input wire logic                    rpage_wr_i,
  input wire logic [9:0]              rpage_wdata_i,
  input wire logic                    ps_req_i,
  input wire msag_pkg::msag_ps_kind_t ps_kind_i,
  input wire logic [22:0]             pc_i,
  input wire logic [7:0]              table_page_i,
  input wire logic [15:0]             tbl_ea_i,
  input wire logic                    x_rd_req_i,
  input wire logic [15:0]             x_rd_ptr_i,
  input wire msag_pkg::msag_agu_cfg_t x_rd_cfg_i,
  input wire logic                    x_wr_req_i,
  input wire logic [15:0]             x_wr_ptr_i,
  input wire msag_pkg::msag_agu_cfg_t x_wr_cfg_i,
  input wire logic                    y_rd_req_i,
  input wire logic                    mac_class_i,
  input wire logic [9:0]              data_read_page_o,
  input wire logic [8:0]              data_write_page_o,
  input wire logic                    ps_valid_o,
  input wire logic                    ps_fault_o,
  input wire logic [23:0]             ps_addr_o,
  input wire logic [23:0]             x_rd_addr_o,
  input wire logic                    x_rd_window_o,
  input wire logic [23:0]             x_wr_addr_o,
  input wire logic                    x_wr_in_y_o,
  input wire logic [15:0]             x_wr_ptr_o,
  input wire logic                    y_rd_valid_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Post-modified X accesses: the raw pointer is the effective address.
  logic xr_go;
  logic xw_go;
  assign xr_go = ce_i && x_rd_req_i && !x_rd_cfg_i.pre;
  assign xw_go = ce_i && x_wr_req_i && !x_wr_cfg_i.pre;

  a_page_load: assert property (ce_i && rpage_wr_i |=> data_read_page_o == $past(rpage_wdata_i))
    else $error("read page not loaded");
  a_fetch_addr: assert property (ce_i && ps_req_i && ps_kind_i == msag_pkg::MSAG_PS_FETCH
    |=> ps_valid_o && ps_addr_o == {1'b0, $past(pc_i[22:1]), 1'b0}) else $error("fetch address");
  a_upper_refused: assert property (ce_i && ps_req_i && table_page_i[7] &&
    ps_kind_i == msag_pkg::MSAG_PS_TBL_WR |=> ps_fault_o && !ps_valid_o && ps_addr_o == 24'h000000)
    else $error("upper half write not refused");
  a_config_read: assert property (ce_i && ps_req_i && ps_kind_i == msag_pkg::MSAG_PS_TBL_RD
    |=> ps_valid_o && ps_addr_o == {$past(table_page_i), $past(tbl_ea_i)}) else $error("table read");
  a_read_paged: assert property (xr_go && x_rd_ptr_i[15] && !data_read_page_o[9] |=> !x_rd_window_o
    && x_rd_addr_o == {$past(data_read_page_o[8:0]), $past(x_rd_ptr_i[14:0])}) else $error("read page");
  a_write_paged: assert property (xw_go && x_wr_ptr_i[15]
    |=> x_wr_addr_o == {$past(data_write_page_o), $past(x_wr_ptr_i[14:0])}) else $error("write page");
  a_base_direct: assert property (xr_go && !x_rd_ptr_i[15]
    |=> x_rd_addr_o == {8'h00, $past(x_rd_ptr_i)}) else $error("base access paged");
  a_window_read: assert property (xr_go && x_rd_ptr_i[15] && data_read_page_o[9]
    |=> x_rd_window_o) else $error("program window not flagged");
  a_y_mac_only: assert property (ce_i && y_rd_req_i && !mac_class_i |=> !y_rd_valid_o)
    else $error("Y read outside multiply class");
  a_linear_walk: assert property (ce_i && x_wr_req_i && !x_wr_cfg_i.mod_en && !x_wr_cfg_i.brev_en
    |=> x_wr_ptr_o == $past(x_wr_ptr_i) + $past(x_wr_cfg_i.step)) else $error("linear step");
  a_boundary_fixed: assert property (xw_go && !x_wr_ptr_i[15]
    |=> x_wr_in_y_o == ($past(x_wr_ptr_i) >= 16'h4000)) else $error("X/Y boundary");
endmodule : msag_top_sva

// >>> dv/msag_mem_model.sv
/* Stand-in for the data memory arrays: counts cycles in which the X and Y
   read paths deliver together. Assumes registered valids from the top. */
`timescale 1ns/10ps
module msag_mem_model (
  input  wire logic       clk_sys_i,
  input  wire logic       x_rd_valid_i,
  input  wire logic       y_rd_valid_i,
  output logic      [7:0] dual_cnt_o
);
  // Both arrays answer in the same cycle, so one dual fetch is one count.
  initial dual_cnt_o = 8'h00;
  always @(posedge clk_sys_i) begin
    if (x_rd_valid_i && y_rd_valid_i) dual_cnt_o <= dual_cnt_o + 8'h01;
  end
endmodule : msag_mem_model

// >>> dv/msag_top_test.sv
/* Bench for the address generator: a table of X accesses, then program space,
   window, circular, bit-reverse, Y and reset cases. Assumes package compiled. */
`timescale 1ns/10ps
module msag_top_test;
  typedef struct packed {
    logic wr; logic [15:0] ptr, step; logic [23:0] addr; logic [15:0] nptr; logic flag;
  } msag_row_t;
  logic clk_sys_i, resetn_i, ce_i, rpage_wr_i, wpage_wr_i, ps_req_i, ps_valid_o, ps_fault_o;
  logic x_rd_req_i, x_wr_req_i, y_rd_req_i, mac_class_i, x_rd_valid_o, x_rd_window_o;
  logic x_wr_valid_o, x_wr_in_y_o, y_rd_valid_o;
  logic [9:0]  rpage_wdata_i, data_read_page_o;
  logic [8:0]  wpage_wdata_i, data_write_page_o;
  logic [22:0] pc_i;
  logic [7:0]  table_page_i, dual_cnt;
  logic [15:0] tbl_ea_i, x_rd_ptr_i, x_wr_ptr_i, y_rd_ptr_i, x_rd_ptr_o, x_wr_ptr_o;
  logic [15:0] y_rd_addr_o, y_rd_ptr_o;
  logic [23:0] ps_addr_o, x_rd_addr_o, x_wr_addr_o;
  msag_pkg::msag_ps_kind_t ps_kind_i;
  msag_pkg::msag_agu_cfg_t x_rd_cfg_i, x_wr_cfg_i, y_rd_cfg_i;
  int errors = 0, num_checks = 0, cyc = 0, i;
  // Pages are 0x0A5 (read) and 0x1C3 (write) while these rows run.
  msag_row_t rows [6] = '{'{1'b0, 16'h1234, 16'h0002, 24'h001234, 16'h1236, 1'b0},
    '{1'b0, 16'h8010, 16'h0002, 24'h528010, 16'h8012, 1'b0},
    '{1'b0, 16'hFFFE, 16'h0002, 24'h52FFFE, 16'h0000, 1'b0},
    '{1'b1, 16'h8000, 16'hFFFE, 24'hE18000, 16'h7FFE, 1'b0},
    '{1'b1, 16'h4000, 16'h0002, 24'h004000, 16'h4002, 1'b1},
    '{1'b1, 16'h3FFE, 16'h0002, 24'h003FFE, 16'h4000, 1'b0}};

  msag_top dut_u (.clk_sys_i, .resetn_i, .ce_i, .rpage_wr_i, .rpage_wdata_i, .wpage_wr_i,
    .wpage_wdata_i, .ps_req_i, .ps_kind_i, .pc_i, .table_page_i, .tbl_ea_i, .x_rd_req_i,
    .x_rd_ptr_i, .x_rd_cfg_i, .x_wr_req_i, .x_wr_ptr_i, .x_wr_cfg_i, .y_rd_req_i,
    .mac_class_i, .y_rd_ptr_i, .y_rd_cfg_i, .data_read_page_o, .data_write_page_o,
    .ps_valid_o, .ps_addr_o, .ps_fault_o, .x_rd_valid_o, .x_rd_addr_o, .x_rd_window_o,
    .x_rd_ptr_o, .x_wr_valid_o, .x_wr_addr_o, .x_wr_in_y_o, .x_wr_ptr_o, .y_rd_valid_o,
    .y_rd_addr_o, .y_rd_ptr_o);
  msag_mem_model mem_u (.clk_sys_i, .x_rd_valid_i(x_rd_valid_o), .y_rd_valid_i(y_rd_valid_o),
    .dual_cnt_o(dual_cnt));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  function automatic msag_pkg::msag_agu_cfg_t cf(input logic [15:0] st, input logic p, m,
                                                 input logic [15:0] s, e, input logic b);
    cf = {st, p, m, s, e, b};
  endfunction : cf

  task automatic chk(input string n, input logic [23:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Inputs always move 5 ns after the rising edge, clear of sampling.
  task automatic tick;
    @(posedge clk_sys_i);
    #5;
  endtask : tick

  // One-cycle request strobes; results are settled when this returns.
  task automatic fire(input logic xr, xw, yr, ps);
    tick;
    {x_rd_req_i, x_wr_req_i, y_rd_req_i, ps_req_i} = {xr, xw, yr, ps};
    tick;
    {x_rd_req_i, x_wr_req_i, y_rd_req_i, ps_req_i} = 4'h0;
  endtask : fire

  task automatic pages(input logic [9:0] r, input logic [8:0] w);
    {rpage_wdata_i, wpage_wdata_i} = {r, w};
    tick;
    {rpage_wr_i, wpage_wr_i} = 2'b11;
    tick;
    {rpage_wr_i, wpage_wr_i} = 2'b00;
  endtask : pages

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // A hung handshake ends the run as a failure; the full run is under 100 cycles.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 400) begin
      errors++;
      conclude;
    end
  end

  initial begin
    {ce_i, rpage_wr_i, wpage_wr_i, ps_req_i, x_rd_req_i, x_wr_req_i, y_rd_req_i} = 7'h40;
    {resetn_i, mac_class_i, rpage_wdata_i, wpage_wdata_i, pc_i, table_page_i} = '0;
    {tbl_ea_i, x_rd_ptr_i, x_wr_ptr_i, y_rd_ptr_i} = '0;
    {x_rd_cfg_i, x_wr_cfg_i, y_rd_cfg_i} = '0;
    ps_kind_i = msag_pkg::MSAG_PS_FETCH;
    repeat (4) tick;
    resetn_i = 1'b1;
    chk("read_page", 24'(data_read_page_o), 24'h000000);
    pages(10'h0A5, 9'h1C3);
    chk("write_page", 24'(data_write_page_o), 24'h0001C3);
    for (i = 0; i < 6; i++) begin
      {x_rd_ptr_i, x_wr_ptr_i} = {2{rows[i].ptr}};
      {x_rd_cfg_i, x_wr_cfg_i} = {2{cf(rows[i].step, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0)}};
      fire(!rows[i].wr, rows[i].wr, 1'b0, 1'b0);
      if (rows[i].wr) begin
        chk("wr_addr", x_wr_addr_o, rows[i].addr);
        chk("wr_ptr", 24'(x_wr_ptr_o), 24'(rows[i].nptr));
        chk("in_y", 24'({x_wr_valid_o, x_wr_in_y_o}), 24'({1'b1, rows[i].flag}));
      end else begin
        chk("rd_addr", x_rd_addr_o, rows[i].addr);
        chk("rd_ptr", 24'({x_rd_valid_o, x_rd_ptr_o}), 24'({1'b1, rows[i].nptr}));
      end
      $display("row %0d done", i);
    end
    pc_i = 23'h7FFFFF;
    fire(1'b0, 1'b0, 1'b0, 1'b1);
    chk("fetch", ps_addr_o, 24'h7FFFFE);
    ps_kind_i = msag_pkg::MSAG_PS_TBL_WR;
    {table_page_i, tbl_ea_i} = {8'h80, 16'h0005};
    fire(1'b0, 1'b0, 1'b0, 1'b1);
    chk("fault", 24'({ps_fault_o, ps_valid_o}), 24'h000002);
    chk("fault_addr", ps_addr_o, 24'h000000);
    ps_kind_i = msag_pkg::MSAG_PS_TBL_RD;
    fire(1'b0, 1'b0, 1'b0, 1'b1);
    chk("cfg_valid", 24'(ps_valid_o), 24'h000001);
    chk("cfg_read", ps_addr_o, 24'h800005);
    $display("program space test done");
    pages(10'h203, 9'h1C3);
    x_rd_ptr_i = 16'h8004;
    fire(1'b1, 1'b0, 1'b0, 1'b0);
    chk("window", 24'(x_rd_window_o), 24'h000001);
    chk("win_addr", x_rd_addr_o, 24'h018004);
    x_rd_ptr_i = 16'h1006;
    x_rd_cfg_i = cf(16'h0002, 1'b0, 1'b1, 16'h1000, 16'h1006, 1'b0);
    y_rd_ptr_i = 16'h1000;
    y_rd_cfg_i = cf(16'hFFFE, 1'b0, 1'b1, 16'h1000, 16'h1006, 1'b0);
    mac_class_i = 1'b1;
    fire(1'b1, 1'b0, 1'b1, 1'b0);
    chk("x_circ", 24'(x_rd_ptr_o), 24'h001000);
    chk("y_circ", 24'({y_rd_valid_o, y_rd_addr_o}), 24'h011000);
    chk("y_ptr", 24'(y_rd_ptr_o), 24'h001006);
    {mac_class_i, y_rd_ptr_i} = {1'b0, 16'h2000};
    fire(1'b0, 1'b0, 1'b1, 1'b0);
    chk("y_refused", 24'({y_rd_valid_o, y_rd_ptr_o}), 24'h001006);
    chk("dual", 24'(dual_cnt), 24'h000001);
    {x_rd_ptr_i, x_wr_ptr_i} = {2{16'h0008}};
    {x_rd_cfg_i, x_wr_cfg_i} = {2{cf(16'h0008, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1)}};
    fire(1'b1, 1'b1, 1'b0, 1'b0);
    chk("brev_wr", 24'(x_wr_ptr_o), 24'h000004);
    chk("brev_rd", 24'(x_rd_ptr_o), 24'h000010);
    $display("data space test done");
    ce_i = 1'b0;
    pages(10'h111, 9'h011);
    chk("frozen", 24'(data_read_page_o), 24'h000203);
    {ce_i, resetn_i} = 2'b10;
    tick;
    resetn_i = 1'b1;
    chk("rereset", 24'({data_read_page_o, data_write_page_o}), 24'h000000);
    $display("reset test done");
    conclude;
  end
endmodule : msag_top_test

bind msag_top msag_top_sva chk_u (.clk_sys_i, .resetn_i, .ce_i, .rpage_wr_i, .rpage_wdata_i,
  .ps_req_i, .ps_kind_i, .pc_i, .table_page_i, .tbl_ea_i, .x_rd_req_i, .x_rd_ptr_i,
  .x_rd_cfg_i, .x_wr_req_i, .x_wr_ptr_i, .x_wr_cfg_i, .y_rd_req_i, .mac_class_i,
  .data_read_page_o, .data_write_page_o, .ps_valid_o, .ps_fault_o, .ps_addr_o, .x_rd_addr_o,
  .x_rd_window_o, .x_wr_addr_o, .x_wr_in_y_o, .x_wr_ptr_o, .y_rd_valid_o);
